/* dv/acr_host_model.sv */
`timescale 1ns/1ps
module acr_host_model (
   // Clock
   input  wire logic       clk_in,
   // Requests toward the device
   output logic      [7:0] reg_addr_out,
   output logic            reg_rd_out,
   output logic            reg_wr_out,
   output logic      [7:0] reg_wdata_out,
   output logic            fifo_empty_out,
   // Answers from the device
   input  wire logic [7:0] reg_rdata_in,
   input  wire logic [7:0] next_addr_in,
   input  wire logic       ready_clear_in
);
   initial begin
      reg_addr_out   = 8'h00;
      reg_rd_out     = 1'b0;
      reg_wr_out     = 1'b0;
      reg_wdata_out  = 8'h00;
      fifo_empty_out = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Released lines show the inverse so a stale value is never mistaken for data
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic [7:0] n,
                     output logic c);
      @(negedge clk_in);
      reg_addr_out = a;
      reg_rd_out   = 1'b1;
      @(negedge clk_in);
      reg_rd_out   = 1'b0;
      reg_addr_out = ~a;
      d            = reg_rdata_in;
      n            = next_addr_in;
      c            = ready_clear_in;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_in);
      reg_addr_out  = a;
      reg_wdata_out = d;
      reg_wr_out    = 1'b1;
      @(negedge clk_in);
      reg_wr_out    = 1'b0;
      reg_addr_out  = ~a;
      reg_wdata_out = ~d;
   endtask

   // Host empties the buffer after a gated sleep
   task automatic flush();
      fifo_empty_out = 1'b1;
      @(negedge clk_in);
      fifo_empty_out = 1'b0;
      @(negedge clk_in);
   endtask
endmodule

/* dv/acr_readout_ctrl_tb.sv */
`timescale 1ns/1ps
`include "acr_map.svh"
module acr_readout_ctrl_tb;
   typedef struct packed {
      logic [7:0] ctrl7;
      logic       fast;
      logic [7:0] addr;
      logic [7:0] nxt;
   } acr_row_s;

   logic       clk_in, reset_in, reg_rd_in, reg_wr_in, ready_clear_out, sleep_enable_in;
   logic       fast_read_in, fifo_gate_in, fifo_empty_in, sample_tick_in, sleeping_out;
   logic       sleep_wake_event_out, fifo_gate_error_out, fifo_accept_out, conv_tick_out;
   logic       temp_enabled_out, c;
   logic [1:0] measurement_select_in;
   logic [2:0] active_rate_setting_in, sleep_rate_in, output_sample_rate_out;
   logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, next_addr_out, event_in;
   logic [7:0] event_enable_in, wake_enable_in, temp_sample_in, flag_enable_out;
   logic [7:0] temperature_value_out, d, n;
   int         miscompares, n_compared, cycles;
   acr_row_s   rows [9] = '{'{8'h00, 1'b0, 8'h06, 8'h07}, '{8'h00, 1'b0, 8'h01, 8'h02},
                            '{8'h00, 1'b1, 8'h01, 8'h03}, '{8'h00, 1'b1, 8'h03, 8'h05},
                            '{8'h00, 1'b1, 8'h05, 8'h07}, '{8'h00, 1'b1, 8'h02, 8'h03},
                            '{8'h20, 1'b1, 8'h06, 8'h07}, '{8'h20, 1'b0, 8'h05, 8'h06},
                            '{8'h20, 1'b0, 8'h06, 8'h33}};

   // Short step periods keep the inactivity runs to tens of cycles
   acr_readout_ctrl #(.STEP_FAST_CYC(4), .STEP_SLOW_CYC(8)) acr_readout_ctrl_inst (
      .clk_in, .reset_in, .reg_addr_in, .reg_rd_in, .reg_wr_in, .reg_wdata_in,
      .reg_rdata_out, .next_addr_out, .ready_clear_out, .sleep_enable_in, .fast_read_in,
      .active_rate_setting_in, .sleep_rate_in, .fifo_gate_in, .measurement_select_in,
      .event_in, .event_enable_in, .wake_enable_in, .fifo_empty_in, .sample_tick_in,
      .temp_sample_in, .sleeping_out, .output_sample_rate_out, .sleep_wake_event_out,
      .fifo_gate_error_out, .fifo_accept_out, .flag_enable_out, .conv_tick_out,
      .temp_enabled_out, .temperature_value_out);

   acr_host_model acr_host_model_inst (
      .clk_in, .reg_addr_out(reg_addr_in), .reg_rd_out(reg_rd_in), .reg_wr_out(reg_wr_in),
      .reg_wdata_out(reg_wdata_in), .fifo_empty_out(fifo_empty_in),
      .reg_rdata_in(reg_rdata_out), .next_addr_in(next_addr_out),
      .ready_clear_in(ready_clear_out));

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk_in = 1'b0;
      forever #2 clk_in = ~clk_in;
   end

   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 3000) begin
         miscompares++;
         results();
      end
   end

   task automatic results();
      if (miscompares == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // Mode change must land inside [lo, hi] cycles, event pulse in the same cycle
   task automatic wait_mode(input logic lvl, input int lo, input int hi, input logic evt);
      int k;
      k = 0;
      while (sleeping_out !== lvl && k < hi) begin
         @(negedge clk_in);
         k++;
      end
      check(8'(k >= lo && sleeping_out === lvl), 8'h01, "mode change time");
      check(8'(sleep_wake_event_out), 8'(evt), "mode change event");
   endtask

   task automatic pulse(input logic [7:0] v);
      event_in = v;
      @(negedge clk_in);
      event_in = 8'h00;
      @(negedge clk_in);
   endtask

   // Events every five cycles for forty cycles, then the mode is checked
   task automatic quiet(input logic en, input logic [7:0] v, input logic exp);
      sleep_enable_in = en;
      repeat (8) begin
         pulse(v);
         repeat (3) @(negedge clk_in);
      end
      check(8'(sleeping_out), 8'(exp), "quiet run mode");
      sleep_enable_in = 1'b0;
      repeat (2) @(negedge clk_in);
   endtask

   task automatic tick();
      @(negedge clk_in);
      sample_tick_in = 1'b1;
      @(negedge clk_in);
      sample_tick_in = 1'b0;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      {sleep_enable_in, fast_read_in, fifo_gate_in, sample_tick_in} = 4'h0;
      {measurement_select_in, active_rate_setting_in, sleep_rate_in} = 8'h00;
      {event_in, event_enable_in, wake_enable_in, temp_sample_in} = 32'h0000_0000;
      reset_in = 1'b1;
      repeat (12) @(negedge clk_in);
      reset_in = 1'b0;
      acr_host_model_inst.rd(`ACR_ADDR_INACT, d, n, c);
      check(d, `ACR_RST_INACT, "inactivity reset");
      acr_host_model_inst.rd(`ACR_ADDR_CTRL7, d, n, c);
      check(d, `ACR_RST_CTRL7, "readout control reset");
      acr_host_model_inst.wr(8'h10, 8'h55);
      acr_host_model_inst.rd(8'h10, d, n, c);
      check(d, 8'h00, "unmapped read");
      acr_host_model_inst.wr(`ACR_ADDR_INACT, 8'ha5);
      acr_host_model_inst.rd(`ACR_ADDR_INACT, d, n, c);
      check(d, 8'ha5, "inactivity readback");
      foreach (rows[i]) begin
         fast_read_in = rows[i].fast;
         acr_host_model_inst.wr(`ACR_ADDR_CTRL7, rows[i].ctrl7);
         acr_host_model_inst.rd(rows[i].addr, d, n, c);
         check(n, rows[i].nxt, "next address");
      end
      acr_host_model_inst.rd(`ACR_ADDR_CTRL7, d, n, c);
      check(d, 8'h20, "readout control readback");
      acr_host_model_inst.rd(`ACR_ADDR_ZLSB, d, n, c);
      acr_host_model_inst.rd(n, d, n, c);
      check(d, `ACR_CLEAR_VALUE, "clear address data");
      check(8'(c), 8'h01, "ready clear pulse");
      // Gated sleep entry, blocked wakes, then a real wake
      acr_host_model_inst.wr(`ACR_ADDR_INACT, 8'h03);
      {event_enable_in, sleep_rate_in, fifo_gate_in, sleep_enable_in} = 13'h1feb;
      wait_mode(1'b1, 10, 20, 1'b1);
      check(8'(output_sample_rate_out), 8'h02, "sleep rate");
      check(8'({fifo_gate_error_out, fifo_accept_out}), 8'h02, "gate on sleep");
      check(flag_enable_out, 8'hbe, "flags in sleep");
      event_enable_in = 8'hdf;
      wake_enable_in = 8'h20;
      pulse(8'h20);
      check(8'(sleeping_out), 8'h01, "disabled source");
      event_enable_in = 8'hff;
      wake_enable_in = 8'h40;
      pulse(8'h40);
      check(8'(sleeping_out), 8'h01, "buffer event");
      wake_enable_in = 8'h00;
      pulse(8'h20);
      check(8'(sleeping_out), 8'h01, "wake not enabled");
      wake_enable_in = 8'h20;
      event_in = 8'h20;
      wait_mode(1'b0, 1, 3, 1'b1);
      event_in = 8'h00;
      check(8'(output_sample_rate_out), 8'h00, "active rate");
      check(flag_enable_out, 8'hfe, "flags after wake");
      check(8'(fifo_gate_error_out), 8'h01, "gate held");
      acr_host_model_inst.flush();
      check(8'({fifo_gate_error_out, fifo_accept_out}), 8'h01, "gate cleared");
      sleep_enable_in = 1'b0;
      fifo_gate_in = 1'b0;
      quiet(1'b1, 8'h40, 1'b0);
      quiet(1'b1, 8'h81, 1'b1);
      quiet(1'b0, 8'h00, 1'b0);
      event_enable_in = 8'hbf;
      quiet(1'b1, 8'h40, 1'b1);
      // Slowest rate doubles the step; sleep event source disabled
      {event_enable_in, active_rate_setting_in, sleep_enable_in} = 12'h7ff;
      wait_mode(1'b1, 20, 40, 1'b0);
      check(8'(fifo_gate_error_out), 8'h00, "no gate");
      sleep_enable_in = 1'b0;
      wait_mode(1'b0, 1, 3, 1'b0);
      active_rate_setting_in = 3'h0;
      // Temperature pairs, then axes only
      measurement_select_in = 2'h3;
      temp_sample_in = 8'he7;
      tick();
      check(8'(conv_tick_out), 8'h00, "first tick of pair");
      tick();
      check(8'(conv_tick_out), 8'h01, "second tick of pair");
      check(temperature_value_out, 8'he7, "temperature capture");
      acr_host_model_inst.rd(`ACR_ADDR_ZMSB, d, n, c);
      acr_host_model_inst.rd(`ACR_ADDR_TEMP, d, n, c);
      check(d, 8'he7, "temperature read");
      measurement_select_in = 2'h0;
      temp_sample_in = 8'h19;
      tick();
      check(8'(conv_tick_out), 8'h01, "axes tick");
      check(temperature_value_out, 8'he7, "no conversion");
      for (int s = 0; s < 4; s++) begin
         measurement_select_in = 2'(s);
         @(negedge clk_in);
         check(8'(temp_enabled_out), 8'(s == 3), "temperature select");
      end
      results();
   end
endmodule

/* verilog/acr_map.svh */
`ifndef ACR_MAP_SVH
`define ACR_MAP_SVH

// Register addresses
`define ACR_ADDR_INACT  8'h29
`define ACR_ADDR_TEMP   8'h51
`define ACR_ADDR_CTRL7  8'h5c
`define ACR_ADDR_CLEAR  8'h33
`define ACR_ADDR_XMSB   8'h01
`define ACR_ADDR_YMSB   8'h03
`define ACR_ADDR_ZMSB   8'h05
`define ACR_ADDR_ZLSB   8'h06
`define ACR_ADDR_AFTER  8'h07

// Field positions and values
`define ACR_CTRL7_AINC  5
`define ACR_RST_INACT   8'h00
`define ACR_RST_CTRL7   8'h00
`define ACR_CLEAR_VALUE 8'h00
`define ACR_MEAS_BOTH   2'h3

// Event vector positions, same as the interrupt enable layout
`define ACR_EV_ASLP     7
`define ACR_EV_DRDY     0
`define ACR_RESTART_MSK 8'h7e
`define ACR_WAKE_MSK    8'h3e
`define ACR_SLEEP_MSK   8'hbe

// Rate codes and inactivity step timing
`define ACR_RATE_SLOW   3'h7
`define ACR_CLK_KHZ     250000
`define ACR_STEP_FAST_MS 320
`define ACR_STEP_SLOW_MS 640
`define ACR_STEP_FAST_CYC (`ACR_STEP_FAST_MS * `ACR_CLK_KHZ)
`define ACR_STEP_SLOW_CYC (`ACR_STEP_SLOW_MS * `ACR_CLK_KHZ)

`endif

/* verilog/acr_pkg.sv */
package acr_pkg;

   typedef enum logic {
      ACR_ACTIVE = 1'b0,
      ACR_SLEEP  = 1'b1
   } acr_mode_e;

   typedef struct packed {
      acr_mode_e  mode;
      logic [7:0] inact;
      logic [7:0] ctrl7;
      logic [7:0] temp;
      logic [7:0] rdata;
      logic [7:0] nptr;
      logic       ready_clr;
      logic       aslp_evt;
      logic       fgerr;
      logic       drdy_off;
      logic       half;
      logic       conv;
   } acr_ctl_s;

   typedef struct packed {
      logic [31:0] div;
      logic [7:0]  count;
   } acr_tmr_s;

endpackage

/* verilog/acr_readout_ctrl.sv */
`timescale 1ns/1ps
`include "acr_map.svh"
module acr_readout_ctrl #(
   parameter int STEP_FAST_CYC = `ACR_STEP_FAST_CYC,
   parameter int STEP_SLOW_CYC = `ACR_STEP_SLOW_CYC
) (
   // Clock and reset
   input  wire logic       clk_in,
   input  wire logic       reset_in,
   // Register port
   input  wire logic [7:0] reg_addr_in,
   input  wire logic       reg_rd_in,
   input  wire logic       reg_wr_in,
   input  wire logic [7:0] reg_wdata_in,
   output logic      [7:0] reg_rdata_out,
   output logic      [7:0] next_addr_out,
   output logic            ready_clear_out,
   // Configuration bits
   input  wire logic       sleep_enable_in,
   input  wire logic       fast_read_in,
   input  wire logic [2:0] active_rate_setting_in,
   input  wire logic [2:0] sleep_rate_in,
   input  wire logic       fifo_gate_in,
   input  wire logic [1:0] measurement_select_in,
   // Event sources and enables
   input  wire logic [7:0] event_in,
   input  wire logic [7:0] event_enable_in,
   input  wire logic [7:0] wake_enable_in,
   // Acquisition side
   input  wire logic       fifo_empty_in,
   input  wire logic       sample_tick_in,
   input  wire logic [7:0] temp_sample_in,
   // Status outputs
   output logic            sleeping_out,
   output logic      [2:0] output_sample_rate_out,
   output logic            sleep_wake_event_out,
   output logic            fifo_gate_error_out,
   output logic            fifo_accept_out,
   output logic      [7:0] flag_enable_out,
   output logic            conv_tick_out,
   output logic            temp_enabled_out,
   output logic      [7:0] temperature_value_out
);
   if (STEP_FAST_CYC < 1 || STEP_SLOW_CYC < 1) begin : g_chk
      $error("step period must be at least one cycle");
   end

   acr_pkg::acr_ctl_s s;
   acr_pkg::acr_ctl_s next_s;
   acr_tmr_if         tmr_bus ();

   logic restart_any;
   logic wake_any;
   logic temp_en;
   logic go_sleep;

   ////////////////////////////////////////////////////////////////////////////
   // Address pointer for bursts

   function automatic logic [7:0] next_addr(
      input logic [7:0] addr,
      input logic       fast,
      input logic       ainc
   );
      logic [7:0] r;
      r = addr + 8'h01;
      if (fast && (addr == `ACR_ADDR_XMSB || addr == `ACR_ADDR_YMSB)) begin
         r = addr + 8'h02;
      end else if (fast && addr == `ACR_ADDR_ZMSB) begin
         r = `ACR_ADDR_AFTER;
      end else if (!fast && ainc && addr == `ACR_ADDR_ZLSB) begin
         r = `ACR_ADDR_CLEAR;
      end
      return r;
   endfunction

   function automatic logic [7:0] read_mux(
      input logic [7:0]        addr,
      input acr_pkg::acr_ctl_s st
   );
      logic [7:0] r;
      r = 8'h00;
      if (addr == `ACR_ADDR_INACT) begin
         r = st.inact;
      end else if (addr == `ACR_ADDR_CTRL7) begin
         r = st.ctrl7;
      end else if (addr == `ACR_ADDR_TEMP) begin
         r = st.temp;
      end else if (addr == `ACR_ADDR_CLEAR) begin
         r = `ACR_CLEAR_VALUE;
      end
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Event qualification

   // A source must be enabled before it may restart the timer or wake
   assign restart_any = |(event_in & event_enable_in & `ACR_RESTART_MSK);
   assign wake_any    = |(event_in & event_enable_in & wake_enable_in
                          & `ACR_WAKE_MSK);
   // Reserved select codes behave as axes only
   assign temp_en     = (measurement_select_in == `ACR_MEAS_BOTH);

   // The sleep/wake event bit is no input here, so it can never hold a change
   assign go_sleep = (s.mode == acr_pkg::ACR_ACTIVE) && sleep_enable_in
                     && !restart_any && (tmr_bus.count >= s.inact);

   assign tmr_bus.restart = restart_any;
   assign tmr_bus.run     = sleep_enable_in && (s.mode == acr_pkg::ACR_ACTIVE);
   assign tmr_bus.slow    = (active_rate_setting_in == `ACR_RATE_SLOW);

   acr_step_timer #(
      .FAST_CYC (STEP_FAST_CYC),
      .SLOW_CYC (STEP_SLOW_CYC)
   ) u_timer (
      .clk_in   (clk_in),
      .reset_in (reset_in),
      .tmr      (tmr_bus.tmr)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      next_s           = s;
      next_s.ready_clr = 1'b0;
      next_s.aslp_evt  = 1'b0;
      next_s.conv      = 1'b0;

      if (reg_wr_in) begin
         if (reg_addr_in == `ACR_ADDR_INACT) begin
            next_s.inact = reg_wdata_in;
         end else if (reg_addr_in == `ACR_ADDR_CTRL7) begin
            next_s.ctrl7 = reg_wdata_in;
         end
      end

      if (reg_rd_in) begin
         next_s.rdata     = read_mux(reg_addr_in, s);
         next_s.nptr      = next_addr(reg_addr_in, fast_read_in,
                                      s.ctrl7[`ACR_CTRL7_AINC]);
         next_s.ready_clr = (reg_addr_in == `ACR_ADDR_CLEAR);
      end

      // Every other tick is a temperature slot, halving the rate
      if (sample_tick_in) begin
         next_s.half = temp_en ? !s.half : 1'b0;
         next_s.conv = !temp_en || s.half;
         if (temp_en && s.half) begin
            next_s.temp = temp_sample_in;
         end
      end

      // Clear first so a new gate error in the same cycle wins
      if (s.fgerr && fifo_empty_in) begin
         next_s.fgerr = 1'b0;
      end
      if (!event_enable_in[`ACR_EV_DRDY]) begin
         next_s.drdy_off = 1'b0;
      end

      if (go_sleep) begin
         next_s.mode     = acr_pkg::ACR_SLEEP;
         next_s.aslp_evt = event_enable_in[`ACR_EV_ASLP];
         next_s.drdy_off = event_enable_in[`ACR_EV_DRDY];
         if (fifo_gate_in) begin
            next_s.fgerr = 1'b1;
         end
      end else if (s.mode == acr_pkg::ACR_SLEEP && (wake_any || !sleep_enable_in)) begin
         next_s.mode     = acr_pkg::ACR_ACTIVE;
         next_s.aslp_evt = event_enable_in[`ACR_EV_ASLP];
      end
   end

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         s       <= '0;
         s.inact <= `ACR_RST_INACT;
         s.ctrl7 <= `ACR_RST_CTRL7;
      end else begin
         s <= next_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign reg_rdata_out          = s.rdata;
   assign next_addr_out          = s.nptr;
   assign ready_clear_out        = s.ready_clr;
   assign sleeping_out           = (s.mode == acr_pkg::ACR_SLEEP);
   assign output_sample_rate_out = sleeping_out ? sleep_rate_in
                                                : active_rate_setting_in;
   assign sleep_wake_event_out   = s.aslp_evt;
   assign fifo_gate_error_out    = s.fgerr;
   // Buffer holds its contents until the host drains it
   assign fifo_accept_out        = !s.fgerr;
   // Ready flag is not restored by wake; host must re-arm it
   assign flag_enable_out        = event_enable_in
                                   & (sleeping_out ? `ACR_SLEEP_MSK : 8'hff)
                                   & ~{7'h00, s.drdy_off};
   assign conv_tick_out          = s.conv;
   assign temp_enabled_out       = temp_en;
   assign temperature_value_out  = s.temp;

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (reset_in);

   a_clear_read: assert property (
      reg_rd_in && reg_addr_in == `ACR_ADDR_CLEAR |=> ready_clear_out && !$past(ready_clear_out)
         || ready_clear_out)
      else $error("ready clear missing after clear read");

   a_clear_value: assert property (
      reg_rd_in && reg_addr_in == `ACR_ADDR_CLEAR |=> reg_rdata_out == 8'h00)
      else $error("clear address read not zero");

   a_ptr_second: assert property (
      reg_rd_in && reg_addr_in == `ACR_ADDR_ZLSB && !fast_read_in
         && s.ctrl7[`ACR_CTRL7_AINC] |=> next_addr_out == `ACR_ADDR_CLEAR)
      else $error("pointer did not jump to clear address");

   a_ptr_plain: assert property (
      reg_rd_in && reg_addr_in == `ACR_ADDR_ZLSB && !s.ctrl7[`ACR_CTRL7_AINC]
         |=> next_addr_out == `ACR_ADDR_AFTER)
      else $error("pointer jumped without secondary mode");

   a_ptr_fast: assert property (
      reg_rd_in && reg_addr_in == `ACR_ADDR_XMSB && fast_read_in
         |=> next_addr_out == `ACR_ADDR_YMSB)
      else $error("fast read did not skip lsb");

   a_sleep_entry: assert property (
      !sleeping_out && sleep_enable_in && !restart_any && tmr_bus.count >= s.inact
         |=> sleeping_out)
      else $error("sleep not entered on expiry");

   a_no_sleep_off: assert property (
      !sleeping_out && !sleep_enable_in |=> !sleeping_out)
      else $error("sleep entered while disabled");

   a_restart_clear: assert property (
      restart_any && !sleeping_out |=> tmr_bus.count == 8'h00 && !sleeping_out)
      else $error("restart did not clear counter");

   a_wake_exit: assert property (
      sleeping_out && wake_any |=> !sleeping_out ##0
         output_sample_rate_out == active_rate_setting_in)
      else $error("wake event did not leave sleep");

   a_mode_event: assert property (
      $changed(sleeping_out) && $past(event_enable_in[`ACR_EV_ASLP]) |-> sleep_wake_event_out)
      else $error("mode change without event");

   a_gate_error: assert property (
      $rose(sleeping_out) && $past(fifo_gate_in) |-> fifo_gate_error_out && !fifo_accept_out)
      else $error("gate error not set on sleep");

   a_temp_update: assert property (
      sample_tick_in && temp_en && s.half |=> temperature_value_out == $past(temp_sample_in)
         ##1 (!conv_tick_out || $past(sample_tick_in)))
      else $error("temperature not updated");

   // Register port
   a_inact_store: assert property (
      reg_wr_in && reg_addr_in == `ACR_ADDR_INACT |=> s.inact == $past(reg_wdata_in))
      else $error("inactivity count not stored");

   a_ctrl_store: assert property (
      reg_wr_in && reg_addr_in == `ACR_ADDR_CTRL7 |=> s.ctrl7 == $past(reg_wdata_in))
      else $error("readout control not stored");

   a_clear_cause: assert property (
      ready_clear_out |-> $past(reg_rd_in) && $past(reg_addr_in) == `ACR_ADDR_CLEAR)
      else $error("ready clear without clear read");

   // Sleep and wake
   a_wake_block: assert property (
      sleeping_out && sleep_enable_in && !wake_any |=> sleeping_out)
      else $error("left sleep without wake event");

   a_mode_quiet: assert property (
      !$changed(sleeping_out) |-> !sleep_wake_event_out)
      else $error("mode event without mode change");

   a_timer_step: assert property (
      $changed(tmr_bus.count)
         |-> tmr_bus.count == 8'h00 || tmr_bus.count == $past(tmr_bus.count) + 8'h01)
      else $error("sleep counter jumped");

   a_gate_hold: assert property (
      fifo_gate_error_out && !fifo_empty_in |=> fifo_gate_error_out)
      else $error("gate error dropped before flush");

   a_gate_clear: assert property (
      fifo_gate_error_out && fifo_empty_in && !go_sleep |=> !fifo_gate_error_out)
      else $error("gate error kept after flush");

   a_ready_kept: assert property (
      $fell(sleeping_out) && $past(event_enable_in[`ACR_EV_DRDY]) && $past(s.drdy_off)
         |-> !flag_enable_out[`ACR_EV_DRDY])
      else $error("ready flag restored by wake");

   // Temperature
   a_axes_only: assert property (
      sample_tick_in && !temp_en
         |=> conv_tick_out && temperature_value_out == $past(temperature_value_out))
      else $error("conversion with temperature off");

   a_half_rate: assert property (
      sample_tick_in && temp_en && !s.half
         |=> !conv_tick_out && temperature_value_out == $past(temperature_value_out))
      else $error("temperature slot not skipped");

   c_sleep: cover property ($rose(sleeping_out));
   c_wake: cover property ($fell(sleeping_out));
   c_burst_clear: cover property (next_addr_out == `ACR_ADDR_CLEAR ##1 ready_clear_out);
   c_gate: cover property ($fell(fifo_gate_error_out));
   c_temp_pair: cover property (sample_tick_in && temp_en && s.half);
endmodule

/* verilog/acr_step_timer.sv */
`timescale 1ns/1ps
module acr_step_timer #(
   parameter int FAST_CYC = 1,
   parameter int SLOW_CYC = 1
) (
   input wire logic clk_in,
   input wire logic reset_in,
   acr_tmr_if.tmr   tmr
);
   if (FAST_CYC < 1 || SLOW_CYC < 1) begin : g_chk
      $error("step period must be at least one cycle");
   end

   localparam logic [31:0] FAST_LAST = 32'(FAST_CYC - 1);
   localparam logic [31:0] SLOW_LAST = 32'(SLOW_CYC - 1);

   acr_pkg::acr_tmr_s s;
   acr_pkg::acr_tmr_s next_s;

   // Count saturates so a long quiet spell never wraps back under the limit
   always_comb begin
      next_s = s;
      if (tmr.restart || !tmr.run) begin
         next_s = '0;
      end else if (s.div == (tmr.slow ? SLOW_LAST : FAST_LAST)) begin
         next_s.div = 32'h0000_0000;
         if (s.count != 8'hff) begin
            next_s.count = s.count + 8'h01;
         end
      end else begin
         next_s.div = s.div + 32'h0000_0001;
      end
   end

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign tmr.count = s.count;
endmodule

/* verilog/acr_tmr_if.sv */
`timescale 1ns/1ps
interface acr_tmr_if;
   logic       restart;
   logic       run;
   logic       slow;
   logic [7:0] count;

   modport ctl (output restart, output run, output slow, input count);
   modport tmr (input restart, input run, input slow, output count);
endinterface
